// [hdl/aial_alarm_bank.sv]
`timescale 1ns/100ps
`default_nettype none

module aial_alarm_bank
  import aial_pkg::*;
#(
  parameter int NCH = AIAL_NCH,
  parameter int NDO = AIAL_NDO
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Control side
  aial_alm_if.bank  alm
);

  typedef struct packed {
    logic [NCH-1:0] hi_st;
    logic [NCH-1:0] lo_st;
    logic [NDO-1:0] do_state;
  } aial_bank_state_t;

  aial_bank_state_t s;
  aial_bank_state_t next_s;

  function automatic logic aial_step(input logic st, input logic [1:0] mode, input logic hit);
    unique case (mode)
      AIAL_MODE_LATCH:  aial_step = st | hit;
      AIAL_MODE_MOMENT: aial_step = hit;
      default:          aial_step = st;
    endcase
  endfunction : aial_step

  always_comb begin
    next_s = s;
    // Clear is applied first so that a hit in the same cycle wins.
    next_s.hi_st = s.hi_st & ~alm.clr_hi;
    next_s.lo_st = s.lo_st & ~alm.clr_lo;
    if (alm.ev_valid) begin
      next_s.hi_st[alm.ev_chan] = aial_step(next_s.hi_st[alm.ev_chan], alm.hi_mode[alm.ev_chan],
                                            alm.ev_hi);
      next_s.lo_st[alm.ev_chan] = aial_step(next_s.lo_st[alm.ev_chan], alm.lo_mode[alm.ev_chan],
                                            alm.ev_lo);
    end
    next_s.do_state = '0;
    for (int i = 0; i < NCH; i++) begin
      if (alm.hi_map_en[i] && next_s.hi_st[i]) begin
        next_s.do_state[alm.hi_line[i]] = 1'b1;
      end
      if (alm.lo_map_en[i] && next_s.lo_st[i]) begin
        next_s.do_state[alm.lo_line[i]] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign alm.hi_st    = s.hi_st;
  assign alm.lo_st    = s.lo_st;
  assign alm.do_state = s.do_state;

endmodule : aial_alarm_bank

`default_nettype wire

// [hdl/aial_if.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Limit memory port bundle
// ****************************************
interface aial_mem_if #(parameter int AW = 3, parameter int DW = 32);
  logic              wr_en;
  logic [AW-1:0]     wr_addr;
  logic [DW-1:0]     wr_data;
  logic [DW/8-1:0]   wr_be;
  logic [AW-1:0]     a_addr;
  logic [DW-1:0]     a_data;
  logic [AW-1:0]     b_addr;
  logic [DW-1:0]     b_data;
  modport host (output wr_en, wr_addr, wr_data, wr_be, a_addr, b_addr, input a_data, b_data);
  modport mem  (input wr_en, wr_addr, wr_data, wr_be, a_addr, b_addr, output a_data, b_data);
endinterface : aial_mem_if

// ****************************************
// Alarm bank bundle
// ****************************************
interface aial_alm_if #(parameter int NCH = 8, parameter int NDO = 8);
  logic                                  ev_valid;
  logic [$clog2(NCH)-1:0]                ev_chan;
  logic                                  ev_hi;
  logic                                  ev_lo;
  logic [NCH-1:0][1:0]                   hi_mode;
  logic [NCH-1:0][1:0]                   lo_mode;
  logic [NCH-1:0]                        hi_map_en;
  logic [NCH-1:0]                        lo_map_en;
  logic [NCH-1:0][$clog2(NDO)-1:0]       hi_line;
  logic [NCH-1:0][$clog2(NDO)-1:0]       lo_line;
  logic [NCH-1:0]                        clr_hi;
  logic [NCH-1:0]                        clr_lo;
  logic [NCH-1:0]                        hi_st;
  logic [NCH-1:0]                        lo_st;
  logic [NDO-1:0]                        do_state;
  modport ctl  (output ev_valid, ev_chan, ev_hi, ev_lo, hi_mode, lo_mode, hi_map_en, lo_map_en,
                hi_line, lo_line, clr_hi, clr_lo, input hi_st, lo_st, do_state);
  modport bank (input ev_valid, ev_chan, ev_hi, ev_lo, hi_mode, lo_mode, hi_map_en, lo_map_en,
                hi_line, lo_line, clr_hi, clr_lo, output hi_st, lo_st, do_state);
endinterface : aial_alm_if

`default_nettype wire

// [hdl/aial_lim_mem.sv]
`timescale 1ns/100ps
`default_nettype none

module aial_lim_mem
  import aial_pkg::*;
#(
  parameter int          DEPTH = 8,
  parameter logic [31:0] RST   = AIAL_LIMIT_RST
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Ports
  aial_mem_if.mem   port
);

  typedef struct packed {
    logic [DEPTH-1:0][31:0] word;
    logic [31:0]            a_q;
    logic [31:0]            b_q;
  } aial_mem_state_t;

  aial_mem_state_t s;
  aial_mem_state_t next_s;

  always_comb begin
    next_s = s;
    if (port.wr_en) begin
      next_s.word[port.wr_addr] = aial_merge(s.word[port.wr_addr], port.wr_data, port.wr_be);
    end
    next_s.a_q = s.word[port.a_addr];
    next_s.b_q = s.word[port.b_addr];
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '{word: {DEPTH{RST}}, a_q: RST, b_q: RST};
    end else begin
      s <= next_s;
    end
  end

  assign port.a_data = s.a_q;
  assign port.b_data = s.b_q;

endmodule : aial_lim_mem

`default_nettype wire

// [hdl/aial_pkg.sv]
package aial_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int AIAL_NCH     = 8;
  localparam int AIAL_DW      = 16;
  localparam int AIAL_NDO     = 8;
  localparam int AIAL_AW      = 5;
  localparam int AIAL_CFG_W   = 12;
  localparam int AIAL_MODE_W  = 2;
  localparam int AIAL_LINE_W  = 3;

  // ****************************************
  // Alarm modes
  // ****************************************
  typedef enum logic [1:0] {
    AIAL_MODE_OFF    = 2'b00,
    AIAL_MODE_LATCH  = 2'b01,
    AIAL_MODE_MOMENT = 2'b11
  } aial_mode_t;

  // ****************************************
  // Register word offsets
  // ****************************************
  localparam logic [4:0] AIAL_REG_RANGE_LO = 5'h00;
  localparam logic [4:0] AIAL_REG_RANGE_HI = 5'h01;
  localparam logic [4:0] AIAL_REG_CLEAR    = 5'h02;
  localparam logic [4:0] AIAL_REG_STATUS   = 5'h03;
  localparam logic [4:0] AIAL_REG_DO_STATE = 5'h04;
  localparam logic [4:0] AIAL_REG_CFG      = 5'h08;
  localparam logic [4:0] AIAL_REG_LIMIT    = 5'h10;
  localparam logic [4:0] AIAL_REG_VALUE    = 5'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int AIAL_CFG_HI_MODE = 0;
  localparam int AIAL_CFG_LO_MODE = 2;
  localparam int AIAL_CFG_HI_EN   = 4;
  localparam int AIAL_CFG_HI_LINE = 5;
  localparam int AIAL_CFG_LO_EN   = 8;
  localparam int AIAL_CFG_LO_LINE = 9;
  localparam int AIAL_STAT_HI     = 0;
  localparam int AIAL_STAT_LO     = 8;
  localparam int AIAL_STAT_OOR    = 16;
  localparam int AIAL_VAL_OOR     = 16;
  localparam int AIAL_VAL_HI      = 17;
  localparam int AIAL_VAL_LO      = 18;
  localparam int AIAL_LIM_LO      = 0;
  localparam int AIAL_LIM_HI      = 16;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [15:0] AIAL_RANGE_LO_RST = 16'h8000;
  localparam logic [15:0] AIAL_RANGE_HI_RST = 16'h7fff;
  localparam logic [11:0] AIAL_CFG_RST      = 12'h000;
  localparam logic [31:0] AIAL_LIMIT_RST    = 32'h7fff_8000;
  localparam logic [15:0] AIAL_OOR_CODE     = 16'h8000;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic aial_in_bank(input logic [4:0] addr, input logic [4:0] base);
    aial_in_bank = (addr[4:3] == base[4:3]);
  endfunction : aial_in_bank

  function automatic logic [31:0] aial_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    aial_merge = (old_v & ~m) | (new_v & m);
  endfunction : aial_merge

endpackage : aial_pkg

// [hdl/aial_top.sv]
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Flag a high alarm when a reading is above the channel's high limit.
// - Flag a low alarm when a reading is below the channel's low limit.
// - An enabled alarm condition drives its status flag high.
// - High and low alarms each have their own mode: off, latched, momentary.
// - Off mode leaves status and mapped output untouched whatever the comparison.
// - Latched mode holds status and mapped output high until software clears it.
// - Software clears a latched alarm; status then returns low.
// - Momentary mode status follows the comparison, high while true, low after.
// - A mapped output line is high while its alarm status is high.
// - In momentary mode the mapped output follows the condition and drops.
// - Software picks the output line per alarm; the new choice applies at once.
// - Software writes high and low limits per channel; later compares use them.
// - A reading outside the input range reads back as an out-of-range code.
module aial_top
  import aial_pkg::*;
#(
  parameter int NCH = AIAL_NCH,
  parameter int DW  = AIAL_DW,
  parameter int NDO = AIAL_NDO
) (
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  // Avalon-MM slave
  input  wire logic [AIAL_AW-1:0]     avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  // Converted samples
  input  wire logic                   sample_valid_i,
  input  wire logic [$clog2(NCH)-1:0] sample_chan_i,
  input  wire logic [DW-1:0]          sample_data_i,
  // Digital output lines
  output logic      [NDO-1:0]         do_o
);

  localparam int CW = $clog2(NCH);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [DW-1:0]                 range_lo;
    logic [DW-1:0]                 range_hi;
    logic [NCH-1:0][AIAL_CFG_W-1:0] cfg;
    logic [NCH-1:0][DW-1:0]        value;
    logic [NCH-1:0]                oor;
    logic                          s1_vld;
    logic [CW-1:0]                 s1_chan;
    logic [DW-1:0]                 s1_data;
    logic                          rd_ack;
    logic                          rd_mem;
    logic [31:0]                   rdata;
  } aial_top_state_t;

  aial_top_state_t s;
  aial_top_state_t next_s;

  aial_mem_if #(.AW(CW), .DW(32)) mem ();
  aial_alm_if #(.NCH(NCH), .NDO(NDO)) alm ();

  aial_lim_mem #(
    .DEPTH (NCH),
    .RST   (AIAL_LIMIT_RST)
  ) u_lim_mem (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .port      (mem.mem)
  );

  aial_alarm_bank #(
    .NCH (NCH),
    .NDO (NDO)
  ) u_alarm_bank (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .alm       (alm.bank)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  logic          rd_new;
  logic          wr_hit;
  logic [CW-1:0] reg_idx;
  logic [DW-1:0] lim_hi;
  logic [DW-1:0] lim_lo;
  logic          cmp_hi;
  logic          cmp_lo;
  logic          cmp_oor;
  logic [31:0]   clr_word;

  assign rd_new  = avs_read_i && !s.rd_ack;
  assign wr_hit  = avs_write_i;
  assign reg_idx = avs_address_i[CW-1:0];

  // Writes finish in the cycle they are presented; reads take one extra cycle
  // so that limit words can come from the registered memory port.
  assign avs_waitrequest_o = avs_read_i && !s.rd_ack;
  assign avs_readdata_o    = s.rd_mem ? mem.a_data : s.rdata;

  assign mem.wr_en   = wr_hit && aial_in_bank(avs_address_i, AIAL_REG_LIMIT);
  assign mem.wr_addr = reg_idx;
  assign mem.wr_data = avs_writedata_i;
  assign mem.wr_be   = avs_byteenable_i;
  assign mem.a_addr  = reg_idx;
  assign mem.b_addr  = sample_chan_i;

  // ****************************************
  // Comparison stage
  // ****************************************
  assign lim_hi  = mem.b_data[AIAL_LIM_HI +: DW];
  assign lim_lo  = mem.b_data[AIAL_LIM_LO +: DW];
  assign cmp_hi  = $signed(s.s1_data) > $signed(lim_hi);
  assign cmp_lo  = $signed(s.s1_data) < $signed(lim_lo);
  assign cmp_oor = ($signed(s.s1_data) < $signed(s.range_lo)) ||
                   ($signed(s.s1_data) > $signed(s.range_hi));

  assign alm.ev_valid = s.s1_vld;
  assign alm.ev_chan  = s.s1_chan;
  assign alm.ev_hi    = cmp_hi;
  assign alm.ev_lo    = cmp_lo;

  // Clear bits only act on the byte lanes that are enabled.
  assign clr_word   = (wr_hit && avs_address_i == AIAL_REG_CLEAR) ?
                      aial_merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i) : 32'h0000_0000;
  assign alm.clr_hi = clr_word[AIAL_STAT_HI +: NCH];
  assign alm.clr_lo = clr_word[AIAL_STAT_LO +: NCH];

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      alm.hi_mode[i]   = s.cfg[i][AIAL_CFG_HI_MODE +: AIAL_MODE_W];
      alm.lo_mode[i]   = s.cfg[i][AIAL_CFG_LO_MODE +: AIAL_MODE_W];
      alm.hi_map_en[i] = s.cfg[i][AIAL_CFG_HI_EN];
      alm.lo_map_en[i] = s.cfg[i][AIAL_CFG_LO_EN];
      alm.hi_line[i]   = s.cfg[i][AIAL_CFG_HI_LINE +: AIAL_LINE_W];
      alm.lo_line[i]   = s.cfg[i][AIAL_CFG_LO_LINE +: AIAL_LINE_W];
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [31:0] rmux;
    rmux   = 32'h0000_0000;
    next_s = s;

    next_s.s1_vld  = sample_valid_i;
    next_s.s1_chan = sample_chan_i;
    next_s.s1_data = sample_data_i;
    if (s.s1_vld) begin
      next_s.value[s.s1_chan] = s.s1_data;
      next_s.oor[s.s1_chan]   = cmp_oor;
    end

    if (wr_hit) begin
      if (avs_address_i == AIAL_REG_RANGE_LO) begin
        next_s.range_lo = DW'(aial_merge(32'(s.range_lo), avs_writedata_i, avs_byteenable_i));
      end
      if (avs_address_i == AIAL_REG_RANGE_HI) begin
        next_s.range_hi = DW'(aial_merge(32'(s.range_hi), avs_writedata_i, avs_byteenable_i));
      end
      if (aial_in_bank(avs_address_i, AIAL_REG_CFG)) begin
        next_s.cfg[reg_idx] = AIAL_CFG_W'(aial_merge(32'(s.cfg[reg_idx]), avs_writedata_i,
                                                     avs_byteenable_i));
      end
    end

    if (avs_address_i == AIAL_REG_RANGE_LO) begin
      rmux = 32'(s.range_lo);
    end else if (avs_address_i == AIAL_REG_RANGE_HI) begin
      rmux = 32'(s.range_hi);
    end else if (avs_address_i == AIAL_REG_STATUS) begin
      rmux[AIAL_STAT_HI +: NCH]  = alm.hi_st;
      rmux[AIAL_STAT_LO +: NCH]  = alm.lo_st;
      rmux[AIAL_STAT_OOR +: NCH] = s.oor;
    end else if (avs_address_i == AIAL_REG_DO_STATE) begin
      rmux = 32'(alm.do_state);
    end else if (aial_in_bank(avs_address_i, AIAL_REG_CFG)) begin
      rmux = 32'(s.cfg[reg_idx]);
    end else if (aial_in_bank(avs_address_i, AIAL_REG_VALUE)) begin
      rmux[DW-1:0]         = s.oor[reg_idx] ? AIAL_OOR_CODE : s.value[reg_idx];
      rmux[AIAL_VAL_OOR]   = s.oor[reg_idx];
      rmux[AIAL_VAL_HI]    = alm.hi_st[reg_idx];
      rmux[AIAL_VAL_LO]    = alm.lo_st[reg_idx];
    end

    next_s.rd_ack = rd_new;
    if (rd_new) begin
      next_s.rd_mem = aial_in_bank(avs_address_i, AIAL_REG_LIMIT);
      next_s.rdata  = rmux;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s          <= '0;
      s.range_lo <= AIAL_RANGE_LO_RST;
      s.range_hi <= AIAL_RANGE_HI_RST;
      s.cfg      <= {NCH{AIAL_CFG_RST}};
    end else begin
      s <= next_s;
    end
  end

  assign do_o = alm.do_state;

endmodule : aial_top

`default_nettype wire

// [tb/aial_top_properties.sv]
`timescale 1ns/100ps
`default_nettype none

module aial_top_properties
  import aial_pkg::*;
#(
  parameter int NCH = AIAL_NCH,
  parameter int DW  = AIAL_DW,
  parameter int NDO = AIAL_NDO
) (
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  // Avalon-MM slave
  input  wire logic [AIAL_AW-1:0]     avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  input  wire logic [31:0]            avs_readdata_o,
  input  wire logic                   avs_waitrequest_o,
  // Converted samples
  input  wire logic                   sample_valid_i,
  input  wire logic [$clog2(NCH)-1:0] sample_chan_i,
  input  wire logic [DW-1:0]          sample_data_i,
  // Digital output lines
  input  wire logic [NDO-1:0]         do_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_read_start;
    avs_read_i && !$past(avs_read_i);
  endsequence
  sequence s_read_ans;
    avs_read_i && !avs_waitrequest_o;
  endsequence
  // A clear with no sample or write nearby can only lower lines, never raise one.
  sequence s_quiet_clear;
    avs_write_i && avs_address_i == AIAL_REG_CLEAR && !sample_valid_i && !$past(sample_valid_i) && !$past(avs_write_i);
  endsequence

  a_do_has_cause: assert property ($changed(do_o) |->
    $past(sample_valid_i, 2) || $past(avs_write_i) || $past(avs_write_i, 2))
    else $error("output lines changed with no sample or write behind it");
  a_clear_no_rise: assert property (s_quiet_clear |=> ((do_o & ~$past(do_o)) == '0))
    else $error("a clear raised an output line");
  a_value_oor_code: assert property (s_read_ans ##0 (avs_address_i[4:3] == 2'b11 &&
    avs_readdata_o[AIAL_VAL_OOR]) |-> avs_readdata_o[15:0] == AIAL_OOR_CODE)
    else $error("out-of-range reading not replaced by the code");
  a_unmapped_zero: assert property (s_read_ans ##0 (avs_address_i inside {5'h05, 5'h06, 5'h07}) |->
    avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read returned nonzero");
  a_status_upper_zero: assert property (s_read_ans ##0 (avs_address_i == AIAL_REG_STATUS) |->
    avs_readdata_o[31:24] == 8'h00)
    else $error("status upper bits set");
  a_read_one_wait: assert property (s_read_start |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read did not take exactly one wait cycle");
  a_write_no_wait: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write was stalled");
  a_wait_only_read: assert property (avs_waitrequest_o |-> avs_read_i && !$past(avs_read_i))
    else $error("wait outside the first read cycle");
endmodule : aial_top_properties

`default_nettype wire

// [tb/aial_top_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module aial_top_tb_top
  import aial_pkg::*;
();
  logic        clk_sys_i;
  logic        rst_i;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wait_req;
  logic        s_valid;
  logic [2:0]  s_chan;
  logic [15:0] s_data;
  logic [7:0]  do_lines;
  int          miscompares;
  int          check_count;

  aial_top u_aial_top (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(address), .avs_read_i(read), .avs_write_i(write),
    .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
    .sample_valid_i(s_valid), .sample_chan_i(s_chan), .sample_data_i(s_data), .do_o(do_lines)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low; a stuck slave ends the run.
  task automatic wait_ack();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    if (wait_req !== 1'b0) begin
      miscompares++;
      $display("ERROR at %0t: waitrequest never went low", $time);
      final_report();
    end
  endtask : wait_ack

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    address <= a;
    wdata   <= d;
    write   <= 1'b1;
    wait_ack();
    write   <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    address <= a;
    read    <= 1'b1;
    wait_ack();
    chk(rdata, exp);
    read    <= 1'b0;
    @(posedge clk_sys_i);
  endtask : rchk

  task automatic dchk(input logic [7:0] exp);
    @(negedge clk_sys_i);
    chk(32'(do_lines), 32'(exp));
    @(posedge clk_sys_i);
  endtask : dchk

  // Status lands two edges after the sample; two more edges leave margin.
  task automatic smp(input logic [2:0] ch, input logic [15:0] d);
    s_valid <= 1'b1;
    s_chan  <= ch;
    s_data  <= d;
    @(posedge clk_sys_i);
    s_valid <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask : smp

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rchk(AIAL_REG_RANGE_LO, 32'h0000_8000);
    rchk(AIAL_REG_RANGE_HI, 32'h0000_7fff);
    rchk(AIAL_REG_CFG, 32'h0000_0000);
    rchk(AIAL_REG_LIMIT, 32'h7fff_8000);
    wr(AIAL_REG_STATUS, 32'hffff_ffff);
    rchk(AIAL_REG_STATUS, 32'h0000_0000);
    wr(5'h05, 32'hffff_ffff);
    rchk(5'h05, 32'h0000_0000);
    dchk(8'h00);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_latch();
    wr(AIAL_REG_LIMIT + 5'h01, 32'h0064_ff9c);
    rchk(AIAL_REG_LIMIT + 5'h01, 32'h0064_ff9c);
    wr(AIAL_REG_CFG + 5'h01, 32'h0000_0051);
    smp(3'h1, 16'h0064);
    rchk(AIAL_REG_STATUS, 32'h0000_0000);
    smp(3'h1, 16'h00c8);
    rchk(AIAL_REG_STATUS, 32'h0000_0002);
    dchk(8'h04);
    smp(3'h1, 16'h0000);
    rchk(AIAL_REG_VALUE + 5'h01, 32'h0002_0000);
    dchk(8'h04);
    wr(AIAL_REG_CFG + 5'h01, 32'h0000_00d1);
    dchk(8'h40);
    wr(AIAL_REG_CLEAR, 32'h0000_0002);
    rchk(AIAL_REG_STATUS, 32'h0000_0000);
    dchk(8'h00);
    $display("t_latch done");
  endtask : t_latch

  task automatic t_moment();
    wr(AIAL_REG_LIMIT + 5'h03, 32'h0064_ff9c);
    wr(AIAL_REG_CFG + 5'h03, 32'h0000_0b0c);
    smp(3'h3, 16'hff38);
    rchk(AIAL_REG_STATUS, 32'h0000_0800);
    dchk(8'h20);
    smp(3'h3, 16'hff9c);
    rchk(AIAL_REG_STATUS, 32'h0000_0000);
    dchk(8'h00);
    $display("t_moment done");
  endtask : t_moment

  task automatic t_off();
    wr(AIAL_REG_LIMIT + 5'h04, 32'h0064_ff9c);
    wr(AIAL_REG_CFG + 5'h04, 32'h0000_0312);
    smp(3'h4, 16'h00c8);
    smp(3'h4, 16'hff38);
    rchk(AIAL_REG_STATUS, 32'h0000_0000);
    dchk(8'h00);
    wr(AIAL_REG_CFG + 5'h04, 32'h0000_0311);
    smp(3'h4, 16'hff38);
    rchk(AIAL_REG_STATUS, 32'h0000_0000);
    smp(3'h4, 16'h00c8);
    rchk(AIAL_REG_STATUS, 32'h0000_0010);
    dchk(8'h01);
    be <= 4'he;
    wr(AIAL_REG_CLEAR, 32'h0000_0010);
    be <= 4'hf;
    dchk(8'h01);
    wr(AIAL_REG_CLEAR, 32'h0000_0010);
    dchk(8'h00);
    $display("t_off done");
  endtask : t_off

  task automatic t_oor();
    wr(AIAL_REG_RANGE_HI, 32'h0000_03e8);
    rchk(AIAL_REG_RANGE_HI, 32'h0000_03e8);
    smp(3'h2, 16'h07d0);
    rchk(AIAL_REG_VALUE + 5'h02, 32'h0001_8000);
    rchk(AIAL_REG_STATUS, 32'h0004_0000);
    smp(3'h2, 16'h01f4);
    rchk(AIAL_REG_VALUE + 5'h02, 32'h0000_01f4);
    $display("t_oor done");
  endtask : t_oor

  initial begin
    miscompares = 0;
    check_count = 0;
    rst_i       = 1'b1;
    address     = 5'h00;
    read        = 1'b0;
    write       = 1'b0;
    wdata       = 32'h0000_0000;
    be          = 4'hf;
    s_valid     = 1'b0;
    s_chan      = 3'h0;
    s_data      = 16'h0000;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset();
    t_latch();
    t_moment();
    t_off();
    t_oor();
    final_report();
  end
endmodule : aial_top_tb_top

bind aial_top aial_top_properties #(.NCH(NCH), .DW(DW), .NDO(NDO)) u_aial_top_properties (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .sample_valid_i(sample_valid_i),
  .sample_chan_i(sample_chan_i), .sample_data_i(sample_data_i), .do_o(do_o)
);

`default_nettype wire
